/* File: bus_alarm_pkg.sv */
// shared constants and carrier types for the bus alarm and interrupt mask block
`default_nettype none

package bus_alarm_pkg;

    // ------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_RX_MASK = 6'h17;
    localparam logic [5:0] IDX_FIFO_MASK = 6'h18;
    localparam logic [5:0] IDX_TXRX_MASK = 6'h19;
    localparam logic [5:0] IDX_IRQ_IND = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    localparam logic [5:0] IDX_A_LATCHED = 6'h22;
    localparam logic [5:0] IDX_A_LIVE = 6'h23;
    localparam logic [5:0] IDX_CLK_LATCHED = 6'h24;
    localparam logic [5:0] IDX_CLK_LIVE = 6'h25;
    localparam logic [5:0] IDX_CTRL = 6'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MASK_EXT_BIT = 6;
    localparam int MASK_A_BIT = 5;
    localparam int MASK_B_BIT = 4;
    localparam int LIVE_DROP_LOC_BIT = 7;
    localparam int LIVE_ADD_LOC_BIT = 6;
    localparam int LIVE_PAR_BIT = 5;
    localparam int CLK_EXT_BIT = 7;
    localparam int CTRL_HW_IEN_BIT = 0;
    localparam int CTRL_AIS_SEL_BIT = 1;
    localparam int CTRL_ADD_TIMING_BIT = 2;
    localparam int CTRL_ODD_PAR_BIT = 3;
    localparam int CTRL_FMT_LSB = 4;
    localparam logic [1:0] FMT_AU3 = 2'h0;
    localparam logic [1:0] FMT_AU4 = 2'h1;
    localparam logic [1:0] FMT_STS1 = 2'h2;

    // ------------------------------------------------------------
    // reset values, bus answers, timing
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int LOSS_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rxA;
        logic [3:0] rxB;
        logic [3:0] fifoTxA;
        logic [3:0] fifoTxB;
        logic [3:0] fifoRx;
        logic [3:0] txPort;
        logic [3:0] remoteFailA;
        logic [3:0] remoteFailB;
    } port_alarm_type;

    typedef struct packed {
        logic [7:0] data;
        logic parity;
    } drop_bus_type;

    typedef struct packed {
        logic [7:0] data;
        logic parity;
        logic indicator;
    } add_bus_type;

endpackage : bus_alarm_pkg

`default_nettype wire

/* File: clock_loss_monitor.sv */
// stuck-clock detector for one bus clock sampled by the system clock
`default_nettype none

module clock_loss_monitor #(
    parameter int LIMIT = bus_alarm_pkg::LOSS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    output logic linkRise,
    output logic lossOfClock
);

    localparam int CW = $clog2(LIMIT + 1);

    // elaboration guard
    if (LIMIT < 2) begin : g_bad_limit
        $error("clock_loss_monitor: LIMIT must be at least 2");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [CW-1:0] cnt;
        logic rise;
        logic loss;
    } mon_type;

    mon_type s;
    mon_type nxt;

    // ------------------------------------------------------------
    // edge finding and stall counting
    // ------------------------------------------------------------
    // sync1 feeds sync2 only; edges are found between sync2 and prev
    always_comb begin
        nxt = s;
        nxt.sync1 = linkClk;
        nxt.sync2 = s.sync1;
        nxt.prev = s.sync2;
        nxt.rise = s.sync2 & ~s.prev;
        if (s.sync2 != s.prev) begin
            nxt.cnt = '0;
            nxt.loss = 1'b0;
        end else if (s.cnt == CW'(LIMIT - 1)) begin
            nxt.loss = 1'b1; // counter parks here until an edge
        end else begin
            nxt.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign linkRise = s.rise;
    assign lossOfClock = s.loss;

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (rst);

    stall_declares_a: assert property (s.sync2 == s.prev && s.cnt == CW'(LIMIT - 1) |=> s.loss)
        else $error("stalled clock not flagged as lost");
    edge_clears_a: assert property (s.sync2 != s.prev |=> !s.loss)
        else $error("loss of clock not cleared by a transition");

endmodule : clock_loss_monitor

`default_nettype wire

/* File: bus_alarm_interrupt_masking.sv */
// interrupt masking, A-side drop/add bus alarms and AXI4-Lite registers
`default_nettype none

// Operation
// - ext clock mask gates ext clock indication
// - A-side mask gates A-side indication
// - B-side mask gates B-side indication
// - port mask plus detail mask gate port
// - remote fail alarms bypass receive masks
// - irq pin only with hardware enable set
// - A-side latched register mirrors live bits
// - clock latched register mirrors its live bits
// - drop clock stall flags drop loss
// - drop loss in drop timing silences add
// - add clock stall in add timing silences add
// - drop parity checked every drop clock
// - live bits 4 and 3 read zero
// - third AIS bit pointer or overhead source
// - second AIS bit pointer or overhead source
// - AIS bits 2,1 off for AU-4/STS-1
// - first AIS bit covers first tributary
// - software indication when enabled latched alarm
module bus_alarm_interrupt_masking #(
    parameter int LOSS_LIMIT = bus_alarm_pkg::LOSS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [bus_alarm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [bus_alarm_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic dropClk,
    input wire logic addClk,
    input wire bus_alarm_pkg::drop_bus_type dropBus,
    input wire bus_alarm_pkg::add_bus_type addIn,
    input wire logic [2:0] aisPointer,
    input wire logic [2:0] aisOverhead,
    input wire logic extClockLoss,
    input wire logic [2:0] h4Loss,
    input wire logic bSideAlarm,
    input wire bus_alarm_pkg::port_alarm_type portAlarm,
    output bus_alarm_pkg::add_bus_type addOut,
    output logic addOe_n,
    output logic irqPin
);

    typedef struct packed {
        logic awRdy;
        logic wRdy;
        logic haveAw;
        logic haveW;
        logic [5:0] wIdx;
        logic [7:0] wData;
        logic wLane;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [7:0] rxMask;
        logic [7:0] fifoMask;
        logic [7:0] txRxMask;
        logic [7:0] irqMask;
        logic [7:0] ctrl;
        logic [7:0] aLive;
        logic [7:0] aLat;
        logic [7:0] clkLive;
        logic [7:0] clkLat;
        logic [7:0] ind;
        bus_alarm_pkg::drop_bus_type drop1;
        bus_alarm_pkg::drop_bus_type drop2;
        logic parErr;
        bus_alarm_pkg::add_bus_type addReg;
        logic addOffReg;
        logic irq;
    } state_type;

    state_type s;
    state_type nxt;

    logic dropRise;
    logic dropLoss;
    logic addLoss;
    logic [3:0] portHit;
    logic [3:0] portInd;
    logic [2:0] aisSel;
    logic parMismatch;
    logic silence;
    logic doWrite;
    logic [7:0] clrA;
    logic [7:0] clrClk;
    logic [31:0] rdMux;
    logic rdOk;
    logic [5:0] rdIdx;
    logic extInd;
    logic aInd;
    logic bInd;
    logic swInd;

    // ------------------------------------------------------------
    // clock supervision of both buses
    // ------------------------------------------------------------
    // both clocks share one monitor design so their timing matches
    clock_loss_monitor #(.LIMIT(LOSS_LIMIT)) drop_mon (
        .clk(clk),
        .rst(rst),
        .linkClk(dropClk),
        .linkRise(dropRise),
        .lossOfClock(dropLoss)
    );

    clock_loss_monitor #(.LIMIT(LOSS_LIMIT)) add_mon (
        .clk(clk),
        .rst(rst),
        .linkClk(addClk),
        .linkRise(),
        .lossOfClock(addLoss)
    );

    // ------------------------------------------------------------
    // per-port interrupt qualification
    // ------------------------------------------------------------
    for (genvar p = 0; p < 4; p++) begin : g_port
        // remote fail needs no receive mask
        assign portHit[p] = (portAlarm.rxA[p] & s.rxMask[2*p+1]) | (portAlarm.rxB[p] & s.rxMask[2*p])
            | (portAlarm.fifoTxA[p] & s.fifoMask[2*p+1]) | (portAlarm.fifoTxB[p] & s.fifoMask[2*p])
            | (portAlarm.txPort[p] & s.txRxMask[4+p]) | (portAlarm.fifoRx[p] & s.txRxMask[p])
            | portAlarm.remoteFailA[p] | portAlarm.remoteFailB[p];
        assign portInd[p] = s.irqMask[p] & portHit[p];
    end

    // ------------------------------------------------------------
    // alarm evaluation helpers
    // ------------------------------------------------------------
    // source select for AIS
    assign aisSel = s.ctrl[bus_alarm_pkg::CTRL_AIS_SEL_BIT] ? aisOverhead : aisPointer;
    // even or odd parity over data and parity bit
    assign parMismatch = (^{s.drop2.data, s.drop2.parity}) != s.ctrl[bus_alarm_pkg::CTRL_ODD_PAR_BIT];
    // drop timing silences on drop loss
    // add timing silences on add loss
    assign silence = s.ctrl[bus_alarm_pkg::CTRL_ADD_TIMING_BIT] ? addLoss : dropLoss;
    assign doWrite = s.haveAw & s.haveW & ~s.bValid;
    // write-one-to-clear on the latched registers
    assign clrA = (doWrite && s.wLane && s.wIdx == bus_alarm_pkg::IDX_A_LATCHED) ? s.wData : 8'h00;
    assign clrClk = (doWrite && s.wLane && s.wIdx == bus_alarm_pkg::IDX_CLK_LATCHED) ? s.wData : 8'h00;

    assign extInd = s.irqMask[bus_alarm_pkg::MASK_EXT_BIT] & s.clkLat[bus_alarm_pkg::CLK_EXT_BIT];
    assign aInd = s.irqMask[bus_alarm_pkg::MASK_A_BIT] & ((|s.aLat) | (|s.clkLat[2:0]));
    assign bInd = s.irqMask[bus_alarm_pkg::MASK_B_BIT] & bSideAlarm;
    assign swInd = extInd | aInd | bInd | (|portInd);

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    assign rdIdx = s_axi_araddr[bus_alarm_pkg::ADDR_W-1:2];

    // unmapped words read zero with a slave error
    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        case (rdIdx)
            bus_alarm_pkg::IDX_RX_MASK: rdMux[7:0] = s.rxMask;
            bus_alarm_pkg::IDX_FIFO_MASK: rdMux[7:0] = s.fifoMask;
            bus_alarm_pkg::IDX_TXRX_MASK: rdMux[7:0] = s.txRxMask;
            bus_alarm_pkg::IDX_IRQ_IND: rdMux[7:0] = s.ind;
            bus_alarm_pkg::IDX_IRQ_MASK: rdMux[7:0] = s.irqMask;
            bus_alarm_pkg::IDX_A_LATCHED: rdMux[7:0] = s.aLat;
            bus_alarm_pkg::IDX_A_LIVE: rdMux[7:0] = s.aLive;
            bus_alarm_pkg::IDX_CLK_LATCHED: rdMux[7:0] = s.clkLat;
            bus_alarm_pkg::IDX_CLK_LIVE: rdMux[7:0] = s.clkLive;
            bus_alarm_pkg::IDX_CTRL: rdMux[7:0] = s.ctrl;
            default: rdOk = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = s;
        // write address and data are taken in either order
        if (s_axi_awvalid && s.awRdy) begin
            nxt.haveAw = 1'b1;
            nxt.wIdx = s_axi_awaddr[bus_alarm_pkg::ADDR_W-1:2];
        end
        if (s_axi_wvalid && s.wRdy) begin
            nxt.haveW = 1'b1;
            nxt.wData = s_axi_wdata[7:0];
            nxt.wLane = s_axi_wstrb[0];
        end
        if (s.bValid && s_axi_bready) begin
            nxt.bValid = 1'b0;
        end
        if (doWrite) begin
            nxt.haveAw = 1'b0;
            nxt.haveW = 1'b0;
            nxt.bValid = 1'b1;
            nxt.bResp = bus_alarm_pkg::RESP_OKAY;
            case (s.wIdx)
                bus_alarm_pkg::IDX_RX_MASK: if (s.wLane) nxt.rxMask = s.wData;
                bus_alarm_pkg::IDX_FIFO_MASK: if (s.wLane) nxt.fifoMask = s.wData;
                bus_alarm_pkg::IDX_TXRX_MASK: if (s.wLane) nxt.txRxMask = s.wData;
                bus_alarm_pkg::IDX_IRQ_MASK: if (s.wLane) nxt.irqMask = {1'b0, s.wData[6:0]};
                bus_alarm_pkg::IDX_CTRL: if (s.wLane) nxt.ctrl = s.wData;
                bus_alarm_pkg::IDX_A_LATCHED, bus_alarm_pkg::IDX_CLK_LATCHED: nxt.bResp = bus_alarm_pkg::RESP_OKAY;
                // status words are read only and ignore writes
                bus_alarm_pkg::IDX_IRQ_IND, bus_alarm_pkg::IDX_A_LIVE,
                bus_alarm_pkg::IDX_CLK_LIVE: nxt.bResp = bus_alarm_pkg::RESP_OKAY;
                default: nxt.bResp = bus_alarm_pkg::RESP_SLVERR;
            endcase
        end
        nxt.awRdy = ~nxt.haveAw & ~nxt.bValid;
        nxt.wRdy = ~nxt.haveW & ~nxt.bValid;

        // one read at a time, answered the cycle after the address
        if (s.rValid && s_axi_rready) begin
            nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && s.arRdy) begin
            nxt.rValid = 1'b1;
            nxt.rData = rdMux;
            nxt.rResp = rdOk ? bus_alarm_pkg::RESP_OKAY : bus_alarm_pkg::RESP_SLVERR;
        end
        nxt.arRdy = ~nxt.rValid;

        // drop bus pins pass two flops before the parity check
        nxt.drop1 = dropBus;
        nxt.drop2 = s.drop1;
        // checked once per drop clock rise
        if (dropRise) begin
            nxt.parErr = parMismatch;
        end

        // add loss reported only in add timing
        // bits 4 and 3 tied low
        // upper AIS bits off outside AU-3
        nxt.aLive = {dropLoss,
                     addLoss & s.ctrl[bus_alarm_pkg::CTRL_ADD_TIMING_BIT],
                     s.parErr | (dropRise & parMismatch),
                     2'b00,
                     aisSel[2:1] & {2{s.ctrl[bus_alarm_pkg::CTRL_FMT_LSB+:2] == bus_alarm_pkg::FMT_AU3}},
                     aisSel[0]};
        nxt.clkLive = {extClockLoss, 4'h0, h4Loss};

        // latch A-side on rising live bits
        // latch clock word the same way
        // set wins over a software clear
        nxt.aLat = (s.aLat & ~clrA) | (nxt.aLive & ~s.aLive);
        nxt.clkLat = (s.clkLat & ~clrClk) | (nxt.clkLive & ~s.clkLive);

        nxt.ind = {swInd, extInd, aInd, bInd, portInd};
        nxt.irq = s.ctrl[bus_alarm_pkg::CTRL_HW_IEN_BIT] & swInd;

        nxt.addOffReg = silence;
        nxt.addReg = silence ? '0 : addIn;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign s_axi_awready = s.awRdy;
    assign s_axi_wready = s.wRdy;
    assign s_axi_bvalid = s.bValid;
    assign s_axi_bresp = s.bResp;
    assign s_axi_arready = s.arRdy;
    assign s_axi_rvalid = s.rValid;
    assign s_axi_rdata = s.rData;
    assign s_axi_rresp = s.rResp;
    assign addOut = s.addReg;
    assign addOe_n = s.addOffReg; // high releases the add bus
    assign irqPin = s.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking main_cb @(posedge clk); endclocking
    default disable iff (rst);

    mask_top_zero_a: assert property (s.irqMask[7] == 1'b0)
        else $error("mask bit 7 holds a one");
    ext_ind_gate_a: assert property (s.ind[6] |-> $past(s.irqMask[bus_alarm_pkg::MASK_EXT_BIT]))
        else $error("ext clock indication without its mask");
    a_ind_gate_a: assert property (!s.irqMask[bus_alarm_pkg::MASK_A_BIT] |=> !s.ind[5])
        else $error("A-side indication while masked");
    b_ind_gate_a: assert property (s.irqMask[bus_alarm_pkg::MASK_B_BIT] && bSideAlarm |=> s.ind[4])
        else $error("B-side alarm not indicated");
    remote_fail_a: assert property (s.irqMask[2] && !s.rxMask[5] && portAlarm.remoteFailA[2] |=> s.ind[2])
        else $error("remote fail ignored");
    irq_enable_a: assert property (irqPin |-> $past(s.ctrl[bus_alarm_pkg::CTRL_HW_IEN_BIT]) && $past(swInd))
        else $error("interrupt pin without enable");
    // add bus silenced on drop loss
    add_silence_a: assert property (!s.ctrl[bus_alarm_pkg::CTRL_ADD_TIMING_BIT] && dropLoss
        |=> addOe_n && !addOut.indicator)
        else $error("add bus driven during drop loss");
    add_loss_a: assert property (s.ctrl[bus_alarm_pkg::CTRL_ADD_TIMING_BIT] && addLoss
        |=> addOe_n && s.aLive[bus_alarm_pkg::LIVE_ADD_LOC_BIT])
        else $error("add clock loss not acted on");
    parity_latch_a: assert property (dropRise && parMismatch && !s.aLive[bus_alarm_pkg::LIVE_PAR_BIT]
        |=> s.aLat[bus_alarm_pkg::LIVE_PAR_BIT])
        else $error("parity error not latched");
    live_unused_a: assert property (s.aLive[4:3] == 2'b00)
        else $error("unused live bits set");
    // upper AIS bits in AU-4 format
    ais_format_a: assert property (s.ctrl[bus_alarm_pkg::CTRL_FMT_LSB+:2] == bus_alarm_pkg::FMT_AU4
        [*2] |-> s.aLive[2:1] == 2'b00)
        else $error("AIS bits 2 and 1 active in AU-4 format");
    latch_hold_a: assert property (s.aLat[5] && clrA[5] == 1'b0 |=> s.aLat[5])
        else $error("latched alarm dropped without clear");
    sw_ind_a: assert property (s.irqMask[bus_alarm_pkg::MASK_A_BIT] && (|s.aLat) |=> s.ind[7])
        else $error("software indication missing");

    irq_raised_c: cover property ($rose(irqPin));
    drop_loss_c: cover property ($rose(dropLoss) ##[1:100] $fell(dropLoss));
    clear_race_c: cover property (clrA[5] && nxt.aLive[5] && !s.aLive[5]);

endmodule : bus_alarm_interrupt_masking

`default_nettype wire

/* File: telecom_bus_source.sv */
// drop and add bus source model for the alarm block bench
`default_nettype none
module telecom_bus_source (
    input wire logic runDrop,
    input wire logic runAdd,
    input wire logic badPar,
    output logic dropClk,
    output logic addClk,
    output bus_alarm_pkg::drop_bus_type dropBus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;
    // 320 ns link clocks, stuck while stopped so the loss monitors trip
    initial begin
        {dropClk, addClk} = 2'b00;
        #7;
        forever begin
            #160;
            if (runDrop) dropClk = ~dropClk;
            if (runAdd) addClk = ~addClk;
        end
    end
    // new byte on the falling edge, steady across the rising one
    always @(negedge dropClk) cnt <= cnt + 8'h01;
    // even parity, spoilt only when the bench asks
    assign dropBus = {cnt, ^cnt ^ badPar};
endmodule : telecom_bus_source
`default_nettype wire

/* File: bus_alarm_interrupt_masking_tb_top.sv */
// self-checking bench for the bus alarm and interrupt mask block
`default_nettype none
module bus_alarm_interrupt_masking_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] MSK = bus_alarm_pkg::IDX_IRQ_MASK, IND = bus_alarm_pkg::IDX_IRQ_IND;
    localparam logic [5:0] ALAT = bus_alarm_pkg::IDX_A_LATCHED, ALIV = bus_alarm_pkg::IDX_A_LIVE;
    localparam logic [5:0] CTL = bus_alarm_pkg::IDX_CTRL;
    localparam logic [1:0] OK = bus_alarm_pkg::RESP_OKAY;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b1, rr = 1'b1;
    logic runDrop = 1'b1, runAdd = 1'b1, badPar = 1'b0, extLoss = 1'b0, bAlarm = 1'b0;
    logic awr, wr, bv, arr, rv, irq, oeN, dropClk, addClk;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic [3:0] strb = 4'h1;
    logic [1:0] bresp, rresp;
    logic [2:0] aisPtr = 3'h5, aisOh = 3'h2;
    bus_alarm_pkg::drop_bus_type dropBus;
    bus_alarm_pkg::add_bus_type addOut;
    bus_alarm_pkg::port_alarm_type portAlarm = 32'h0000_0000;
    int errorCnt = 0, totalChecks = 0;
    // device under test, default loss limit of 1000 ns
    bus_alarm_interrupt_masking dut (
        .clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(adr), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(adr), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .dropClk(dropClk), .addClk(addClk),
        .dropBus(dropBus), .addIn(10'h2a5), .aisPointer(aisPtr), .aisOverhead(aisOh), .extClockLoss(extLoss),
        .h4Loss(3'h0), .bSideAlarm(bAlarm), .portAlarm(portAlarm), .addOut(addOut), .addOe_n(oeN), .irqPin(irq));
    // far-end bus source
    telecom_bus_source farEnd (.runDrop(runDrop), .runAdd(runAdd), .badPar(badPar), .dropClk(dropClk),
        .addClk(addClk), .dropBus(dropBus));
    // 25 MHz system clock
    initial forever #20 clk = ~clk;
    // compare one byte-wide result and keep score
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            errorCnt++;
        end
    endtask : chk
    // counts, verdict, end of run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // one register access; a write offers address and data together
    task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        adr <= {idx, 2'h0};
        wd <= 32'(d);
        {awv, wv, arv} <= {w, w, !w};
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr === 1'b1) wv <= 1'b0;
            if (arv && arr === 1'b1) arv <= 1'b0;
            if (bv === 1'b1 || rv === 1'b1) begin
                chk("resp", 8'(er), 8'(w ? bresp : rresp));
                if (!w) chk($sformatf("reg%h", idx), d, rdat[7:0]);
                return;
            end
        end
        chk("busTimeout", 8'h01, 8'h00);
        report_and_stop();
    endtask : acc
    // bounded wait for the add bus enable to reach a level
    task automatic waitOe(input logic v);
        for (int n = 0; n < 60; n++) begin
            @(posedge clk);
            if (oeN === v) return;
        end
        chk("addOe_n", 8'(v), 8'(oeN));
        report_and_stop();
    endtask : waitOe
    // main sequence, requests start one edge after reset release
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(1'b0, MSK, 8'h00, OK);
        acc(1'b1, 6'h3f, 8'h5a, bus_alarm_pkg::RESP_SLVERR);
        for (int f = 0; f < 6; f++) begin
            acc(1'b1, CTL, 8'(f / 2 * 16 + f % 2 * 2), OK);
            acc(1'b0, ALIV, (f < 2) ? 8'(5 - 3 * f) : 8'(1 - f % 2), OK);
        end
        {aisPtr, aisOh} <= 6'h00;
        acc(1'b0, IND, 8'h00, OK);
        acc(1'b1, MSK, 8'h20, OK);
        acc(1'b1, CTL, 8'h01, OK);
        acc(1'b0, ALAT, 8'h07, OK);
        acc(1'b0, IND, 8'ha0, OK);
        chk("irqPin", 8'h01, 8'(irq));
        acc(1'b1, CTL, 8'h00, OK);
        repeat (2) @(posedge clk);
        chk("irqPin", 8'h00, 8'(irq));
        acc(1'b1, ALAT, 8'hff, OK);
        acc(1'b0, IND, 8'h00, OK);
        $display("test A-side interrupt done");
        {extLoss, bAlarm, portAlarm} <= {2'h3, 32'h3000_0040};
        acc(1'b1, bus_alarm_pkg::IDX_RX_MASK, 8'h02, OK);
        acc(1'b1, MSK, 8'h57, OK);
        acc(1'b0, IND, 8'hd5, OK);
        acc(1'b0, bus_alarm_pkg::IDX_CLK_LATCHED, 8'h80, OK);
        $display("test mask levels done");
        runDrop <= 1'b0;
        waitOe(1'b1);
        acc(1'b0, ALIV, 8'h80, OK);
        chk("addIndicator", 8'h00, 8'(addOut.indicator));
        chk("addData", 8'h00, addOut.data);
        runDrop <= 1'b1;
        waitOe(1'b0);
        chk("addData", 8'ha9, addOut.data);
        acc(1'b1, CTL, 8'h04, OK);
        runAdd <= 1'b0;
        waitOe(1'b1);
        runAdd <= 1'b1;
        waitOe(1'b0);
        badPar <= 1'b1;
        repeat (20) @(posedge clk);
        acc(1'b0, ALIV, 8'h20, OK);
        acc(1'b0, ALAT, 8'he0, OK);
        acc(1'b1, CTL, 8'h0c, OK);
        repeat (20) @(posedge clk);
        acc(1'b0, ALIV, 8'h00, OK);
        acc(1'b0, ALAT, 8'he0, OK);
        $display("test bus alarms done");
        report_and_stop();
    end
endmodule : bus_alarm_interrupt_masking_tb_top
`default_nettype wire
